/* verilog/ssc_standby_ctrl.v */
// standby mode control with oscillation stabilization counter and status
//
// Behaviour
// - stop accepted only on main clock
// - halt accepted on either clock
// - low-speed oscillator kept per option byte
// - status bits set in order, stay set
// - counter stops at selected time
// - status shows only up to selected time
// - wait counts only after oscillation starts
// - pending interrupt turns stop into wait
`timescale 1ns/1ps
`include "ssc_defines.vh"

// design notes
//
// bus side
// - the slave never stalls: hreadyout is tied high and hresp stays okay
// - a write lands at the edge that closes its data phase
// - read data is loaded at the address phase edge, so hrdata already
//   stands for the whole data phase and needs no extra wait state
// - offsets outside the four registers read zero and drop writes
//
// standby sequencer
// - run, halt, stop and a stabilization wait, one-hot coded
// - a stop request while the subsystem clock drives the cpu is refused
//   and leaves a sticky flag; software clears it by writing a one
// - if the refusal and the clearing write meet in one cycle, the
//   refusal wins so that no refused stop is ever lost
// - a stop request with an interrupt already pending skips the stop
//   state and goes straight into the stabilization wait
// - halt wakes at once; only a stop request pays the wait
//
// stabilization counter
// - cleared on every entry from run into stop or into the wait, so a status
//   read after release only shows thresholds of this release
// - it only advances once the synchronised oscillation flag is high,
//   so the crystal start-up time is never counted as stable time
// - threshold bits above the selected time are masked off and stay zero
// - the counter freezes as soon as the selected threshold bit is set
//
// limitations
// - the select register is frozen during the wait; a write then is
//   dropped rather than applied late, and software must read it back
// - select values above the number of thresholds are not guarded;
//   with the default parameters every three-bit value is legal
// - the option byte level is taken only while the cpu runs, so a late
//   change of the option pin cannot toggle the low-speed oscillator
//   in the middle of a standby period
// - the oscillation flag crosses clock domains, so it passes three
//   flip-flops and counts only when the last two stages agree; this
//   costs four cycles of latency after the pin rises
//
// trade-off
// - thresholds are plain counter bits rather than comparators, which
//   keeps the status logic to one and-gate and one or-gate per bit

module ssc_standby_ctrl #(
  parameter integer NUM_THR  = `SSC_NUM_THR,
  parameter integer BASE_LOG = `SSC_THR_BASE_LOG2,
  parameter integer CNT_W    = BASE_LOG + NUM_THR
)(
  input  wire        core_clk,
  input  wire        reset,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        halt_req,
  input  wire        stop_req,
  input  wire        irq_pending,
  input  wire        wake_req,
  input  wire        lsosc_keep_opt,
  input  wire        osc_started_pin,
  output wire        halt_mode,
  output wire        stop_mode,
  output wire        lsosc_run,
  output wire        main_osc_run,
  output wire        cpu_clk_en
);

  // one-hot states of the standby sequencer
  localparam [3:0] ST_RUN  = 4'b0001;
  localparam [3:0] ST_HALT = 4'b0010;
  localparam [3:0] ST_STOP = 4'b0100;
  localparam [3:0] ST_WAIT = 4'b1000;

  reg [3:0]         state_q;
  reg [3:0]         state_d;
  reg [1:0]         ctrl_q;
  reg [2:0]         tsel_q;
  reg [NUM_THR-1:0] status_q;
  reg [CNT_W-1:0]   cnt_q;
  reg               refused_q;
  reg               lsopt_q;
  reg [2:0]         osc_sync_q;
  reg               osc_ok_q;
  reg               ph_valid_q;
  reg               ph_write_q;
  reg [11:0]        ph_addr_q;

  wire [NUM_THR-1:0] thr_hit;
  wire [NUM_THR-1:0] thr_allow;
  wire               cnt_done;
  wire               on_sub;

  // bus is always ready and never errors; every access takes one data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign on_sub    = ctrl_q[`SSC_CTRL_SUBCLK];

  // threshold index is enabled when it does not exceed the selected time
  function thr_enabled;
    input [2:0] sel;
    input integer idx;
    begin
      thr_enabled = (idx <= sel);
    end
  endfunction

  // write decode for one register offset, used by several writers
  function reg_write_hit;
    input [11:0] off;
    begin
      reg_write_hit = ph_valid_q && ph_write_q && (ph_addr_q == off);
    end
  endfunction

  // one-cycle write strobes for the control, select and mode registers in the data phase
  wire wr_ctrl = reg_write_hit(`SSC_OFF_CTRL);
  wire wr_tsel = reg_write_hit(`SSC_OFF_TSEL);
  wire wr_mode = reg_write_hit(`SSC_OFF_MODE);

  // option byte level caught by a clocked process after reset release
  always @(posedge core_clk)
  begin
    if (reset)
      lsopt_q <= 1'b0;
    else if (state_q == ST_RUN)
      lsopt_q <= lsosc_keep_opt;
  end

  // oscillation-started pin synchroniser; a change counts when stages agree
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      osc_sync_q <= 3'h0;
      osc_ok_q   <= 1'b0;
    end
    else
    begin
      osc_sync_q <= {osc_sync_q[1:0], osc_started_pin};
      if (osc_sync_q[1] == osc_sync_q[2])
        osc_ok_q <= osc_sync_q[2];
    end
  end

  // standby sequencer next state
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_RUN:
      begin
        if (stop_req && !on_sub && irq_pending)
          state_d = ST_WAIT;
        else if (stop_req && !on_sub)
          state_d = ST_STOP;
        else if (halt_req)
          state_d = ST_HALT;
      end
      ST_HALT:
        if (wake_req || irq_pending)
          state_d = ST_RUN;
      ST_STOP:
        if (wake_req || irq_pending)
          state_d = ST_WAIT;
      ST_WAIT:
        if (cnt_done)
          state_d = ST_RUN;
      default:
        state_d = ST_RUN;
    endcase
  end

  // state register and stop-refusal flag (set wins over a mode write)
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      state_q   <= ST_RUN;
      refused_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == ST_RUN && stop_req && on_sub)
        refused_q <= 1'b1;
      else if (wr_mode)
        refused_q <= refused_q & ~hwdata[`SSC_MODE_REFUSED];
    end
  end

  // counting waits for the oscillator; a stuck count cannot shorten the wait
  wire cnt_run = (state_q == ST_WAIT) && osc_ok_q && !cnt_done;

  // thresholds: bit i fires when count reaches 2^(BASE_LOG+i)
  genvar gi;
  generate
    for (gi = 0; gi < NUM_THR; gi = gi + 1)
    begin : g_thr
      assign thr_hit[gi]   = cnt_q[BASE_LOG+gi];
      assign thr_allow[gi] = thr_enabled(tsel_q, gi);
    end
  endgenerate

  // counter done once the selected threshold is reached
  assign cnt_done = status_q[tsel_q];

  // stabilization counter and status bits
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      cnt_q    <= {CNT_W{1'b0}};
      status_q <= {NUM_THR{1'b0}};
    end
    else if (state_q == ST_RUN && state_d == ST_STOP)
    begin
      cnt_q    <= {CNT_W{1'b0}};
      status_q <= {NUM_THR{1'b0}};
    end
    else if (state_q == ST_RUN && state_d == ST_WAIT)
    begin
      cnt_q    <= {CNT_W{1'b0}};
      status_q <= {NUM_THR{1'b0}};
    end
    else if (cnt_run)
    begin
      cnt_q    <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      status_q <= status_q | (thr_hit & thr_allow);
    end
  end

  // address phase capture and register writes
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_addr_q  <= 12'h000;
      ctrl_q     <= `SSC_RST_CTRL;
      tsel_q     <= `SSC_RST_TSEL;
    end
    else
    begin
      if (hready)
      begin
        ph_valid_q <= hsel && htrans[1];
        ph_write_q <= hwrite;
        ph_addr_q  <= haddr;
      end
      if (wr_ctrl)
        ctrl_q <= hwdata[1:0];
      // select held during the wait so the running count stays coherent
      if (wr_tsel && state_q != ST_WAIT)
        tsel_q <= hwdata[2:0];
    end
  end

  // read data register, loaded in the address phase
  always @(posedge core_clk)
  begin
    if (reset)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      case (haddr)
        `SSC_OFF_CTRL:   hrdata <= {30'h0000_0000, ctrl_q};
        `SSC_OFF_TSEL:   hrdata <= {29'h0000_0000, tsel_q};
        `SSC_OFF_STATUS: hrdata <= {{(32-NUM_THR){1'b0}}, status_q};
        `SSC_OFF_MODE:   hrdata <= {27'h0000_000, refused_q, main_osc_run,
                                    lsosc_run, stop_mode, halt_mode};
        default:         hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // mode outputs; in standby the low-speed oscillator follows the option byte level taken while in run
  assign halt_mode    = state_q[1] | state_q[3];
  assign stop_mode    = state_q[2];
  assign lsosc_run    = (state_q == ST_RUN) | lsopt_q;
  assign main_osc_run = !state_q[2];
  assign cpu_clk_en   = state_q[0];

endmodule

/* verilog/ssc_defines.vh */
// constants for the standby and oscillation stabilization controller
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH
// register byte offsets on the ahb-lite bus
`define SSC_OFF_CTRL      12'h000
`define SSC_OFF_TSEL      12'h004
`define SSC_OFF_STATUS    12'h008
`define SSC_OFF_MODE      12'h00C
// control register fields
`define SSC_CTRL_SUBCLK   0
`define SSC_CTRL_HIOSC    1
// mode register fields
`define SSC_MODE_HALT     0
`define SSC_MODE_STOP     1
`define SSC_MODE_LSRUN    2
`define SSC_MODE_OSCRUN   3
`define SSC_MODE_REFUSED  4
// reset values
`define SSC_RST_TSEL      3'h7
`define SSC_RST_CTRL      2'h0
// number of stabilization thresholds
`define SSC_NUM_THR       8
// first threshold is 2^8 cycles, each next doubles
`define SSC_THR_BASE_LOG2 8
`endif

/* test/ssc_cpu_model.sv */
// cpu core model issuing standby requests
`timescale 1ns/1ps
module ssc_cpu_model (
  input  wire       core_clk,
  input  wire [1:0] cmd,
  output reg        halt_req = 0,
  output reg        stop_req = 0,
  output reg        wake_req = 0
);
  // one pulse per command; the core has already quiesced main-clock
  // peripherals and converter bits and set the select
  always @(posedge core_clk)
  begin
    halt_req <= cmd == 2'd1;
    stop_req <= cmd == 2'd2;
    wake_req <= cmd == 2'd3;
  end
endmodule

/* test/ssc_standby_ctrl_assertions.sv */
// checker for the standby mode outputs
`timescale 1ns/1ps
module ssc_sva (
  input wire core_clk,
  input wire reset,
  input wire halt_req,
  input wire stop_req,
  input wire irq_pending,
  input wire wake_req,
  input wire osc_started_pin,
  input wire halt_mode,
  input wire stop_mode,
  input wire lsosc_run,
  input wire main_osc_run,
  input wire cpu_clk_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // stabilization wait lasts at least six cycles when stop ends with the crystal still silent
  sequence s_wait; $fell(stop_mode) && !osc_started_pin; endsequence
  property p_wait; s_wait |-> halt_mode [*6]; endproperty
  property p_halt; cpu_clk_en && halt_req && !stop_req && !irq_pending && !wake_req
    |=> halt_mode; endproperty
  property p_irq; stop_req && irq_pending |=> !stop_mode; endproperty
  property p_src; $rose(stop_mode) |-> $past(cpu_clk_en); endproperty
  property p_osc; main_osc_run == !stop_mode; endproperty
  property p_run; cpu_clk_en == !(halt_mode || stop_mode); endproperty
  property p_ls; (halt_mode || stop_mode) && $past(halt_mode || stop_mode)
    |-> $stable(lsosc_run); endproperty
  property p_lsr; cpu_clk_en |-> lsosc_run; endproperty
  a_wait: assert property (p_wait) else $error("wait ended early");
  a_halt: assert property (p_halt) else $error("halt not taken");
  a_irq: assert property (p_irq) else $error("stop with irq");
  a_src: assert property (p_src) else $error("stop not from run");
  a_osc: assert property (p_osc) else $error("main osc state");
  a_run: assert property (p_run) else $error("cpu clock state");
  a_ls: assert property (p_ls) else $error("lsosc changed");
  a_lsr: assert property (p_lsr) else $error("lsosc off in run");
endmodule
bind ssc_standby_ctrl ssc_sva u_sva (.*);

/* test/ssc_standby_ctrl_tb.sv */
// self-checking bench for the standby controller
`timescale 1ns/1ps
`include "ssc_defines.vh"
module ssc_standby_ctrl_tb;
  reg core_clk = 0, reset = 1, hsel = 0, hwrite = 0;
  reg irq_pending = 0, lsosc_keep_opt = 1, osc_started_pin = 1;
  reg [11:0] haddr = 0;
  reg [1:0] htrans = 0, cmd = 0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] hwdata = 0, r;
  wire [31:0] hrdata;
  wire hreadyout, hresp, halt_req, stop_req, wake_req;
  wire halt_mode, stop_mode, lsosc_run, main_osc_run, cpu_clk_en;
  wire hready = hreadyout;
  integer mismatches = 0, n_compared = 0, n, m;
  // short thresholds: 4, 8, 16 ... cycles
  ssc_standby_ctrl #(.BASE_LOG(2)) dut (.*);
  ssc_cpu_model cpu (.*);
  always #4 core_clk = ~core_clk;
  task report_and_stop;
  begin
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("wrong value %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  // one bus phase, bounded wait for hready
  task hw;
  begin
    n = 0;
    do
    begin
      @(posedge core_clk);
      n = n + 1;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end
  endtask
  task xf(input w, input [11:0] a, input [31:0] d);
  begin
    hsel <= 1;
    htrans <= 2;
    hwrite <= w;
    haddr <= a;
    hw;
    hsel <= 0;
    htrans <= 0;
    hwdata <= d;
    hw;
    r = hrdata;
  end
  endtask
  task rc(input [11:0] a, input [31:0] e, input string nm);
  begin
    xf(0, a, 0);
    chk(nm, e, r);
  end
  endtask
  // command lands at the design two edges on, settled one edge later
  task cm(input [1:0] c);
  begin
    cmd <= c;
    @(posedge core_clk);
    cmd <= 0;
    repeat (2) @(posedge core_clk);
  end
  endtask
  task wr;
  begin
    m = 0;
    while (cpu_clk_en !== 1'b1 && m < 5000)
    begin
      @(posedge core_clk);
      m = m + 1;
    end
    if (m >= 5000)
    begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge core_clk);
    reset <= 0;
    @(posedge core_clk);
    rc(`SSC_OFF_TSEL, 7, "tsel");
    rc(12'h010, 0, "unmapped");
    xf(1, `SSC_OFF_TSEL, 1);
    osc_started_pin <= 0;
    cm(2);
    chk("stop", 1, stop_mode);
    cm(3);
    repeat (20) @(posedge core_clk);
    chk("wait", 1, halt_mode);
    xf(1, `SSC_OFF_TSEL, 5);
    osc_started_pin <= 1;
    wr;
    // 4 sync edges, 8 counts to the second threshold, 1 to set status, 1 to run, 1 seen late
    chk("cycles", 15, m);
    rc(`SSC_OFF_TSEL, 1, "tsel");
    rc(`SSC_OFF_STATUS, 32'h0000_0003, "status");
    cm(2);
    rc(`SSC_OFF_STATUS, 0, "status");
    cm(3);
    wr;
    xf(1, `SSC_OFF_CTRL, 1);
    cm(2);
    chk("stop", 0, stop_mode);
    rc(`SSC_OFF_MODE, 32'h0000_001C, "mode");
    lsosc_keep_opt <= 0;
    cm(1);
    chk("halt", 1, halt_mode);
    chk("lsosc", 0, lsosc_run);
    cm(3);
    lsosc_keep_opt <= 1;
    cm(1);
    chk("lsosc", 1, lsosc_run);
    cm(3);
    xf(1, `SSC_OFF_CTRL, 0);
    irq_pending <= 1;
    cm(2);
    chk("stop", 0, stop_mode);
    chk("halt", 1, halt_mode);
    wr;
    report_and_stop;
  end
endmodule
